// ---- shared/dtio_regs.vh ----
// Purpose: Constants for the drive terminal conditioning block.
// Assumes: 100 MHz REF_CLK.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef DTIO_REGS_VH
`define DTIO_REGS_VH

`define DTIO_CLK_PERIOD_NS      10
// Change-delay timebase tick, 0.1 s
`define DTIO_TICK_NS            100000000
`define DTIO_TICK_CYCLES        (`DTIO_TICK_NS / `DTIO_CLK_PERIOD_NS)
// Change-delay setting limit in ticks (3600.0 s)
`define DTIO_DELAY_MAX_TICKS    16'd36000
// Cycle-complete pulse width, 250 ms
`define DTIO_PLC_PULSE_NS       250000000
`define DTIO_PLC_PULSE_CYCLES   (`DTIO_PLC_PULSE_NS / `DTIO_CLK_PERIOD_NS)
// Pulse output ceiling 100.00 kHz: least period 10000 ns
`define DTIO_PULSE_MIN_PER_NS   10000
`define DTIO_PULSE_MIN_CYCLES   (`DTIO_PULSE_MIN_PER_NS / `DTIO_CLK_PERIOD_NS)
// Drive overload warning lead, 10 s in 0.1 s units
`define DTIO_OVL_LEAD_TENTHS    16'd100

// Output function selector reset codes
`define DTIO_SEL_MAIN_RST       6'h00
`define DTIO_SEL_BRELAY_RST     6'h02
`define DTIO_SEL_XRELAY_RST     6'h00
`define DTIO_SEL_FIRST_OC_RST   6'h01
`define DTIO_SEL_XOC_RST        6'h04

// Selector indices
`define DTIO_IDX_MAIN           0
`define DTIO_IDX_BRELAY         1
`define DTIO_IDX_XRELAY         2
`define DTIO_IDX_FIRST_OC       3
`define DTIO_IDX_XOC            4

// Function codes handled here
`define DTIO_FN_LAST            6'h0c
`define DTIO_FN_MAX             6'h29

// Main output mode
`define DTIO_MODE_SWITCH        1'b0
`define DTIO_MODE_PULSE         1'b1

`endif

// ---- hdl/dtio_change_delay.v ----
// Purpose: Change delay for one digital input, counted in 0.1 s ticks.
// Assumes: Input already synchronised; tick is a one-cycle pulse.
// Notes:   A change that reverts before expiry is dropped.
`timescale 1ns/1ns
`include "dtio_regs.vh"
module dtio_change_delay #(
  parameter DW = 16
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // Timebase
  input  wire          tick,
  // Setting in ticks
  input  wire [DW-1:0] delay_ticks,
  // Level in and out
  input  wire          level_in,
  output reg           level_out,
  output reg           pending
);

  reg  [DW-1:0] count_r;
  wire [DW-1:0] lim;

  // Settings beyond 3600.0 s are held at the limit
  assign lim = (delay_ticks > `DTIO_DELAY_MAX_TICKS) ? `DTIO_DELAY_MAX_TICKS : delay_ticks;

  always @(posedge clk) begin
    if (!rst_n) begin
      level_out <= 1'b0;
      count_r   <= {DW{1'b0}};
      pending   <= 1'b0;
    end else if (level_in == level_out) begin
      count_r <= {DW{1'b0}};
      pending <= 1'b0;
    end else if (lim == {DW{1'b0}}) begin
      level_out <= level_in;
      pending   <= 1'b0;
    end else begin
      pending <= 1'b1;
      if (tick) begin
        if (count_r + 1'b1 >= lim) begin
          level_out <= level_in;
          count_r   <= {DW{1'b0}};
        end else begin
          count_r <= count_r + 1'b1;
        end
      end
    end
  end

endmodule

// ---- hdl/dtio_top.v ----
// Purpose: Terminal conditioning for a drive control board: analog
//          below-minimum handling, input change delay and polarity,
//          output mode and output function multiplexing.
// Assumes: One 100 MHz clock; status inputs come from same-clock logic;
//          only the digital input pins are asynchronous.
// Notes:   Function codes 13 to 41 are accepted but drive nothing here.
//
// Overview of operation
// - Digit 0 and input under minimum: use that channel's minimum-point setting.
// - Digit 1 and input under minimum: channel setting becomes exactly 0.0%.
// - Three independent below-minimum digits, one per analog channel.
// - Inputs 1 to 3 have 0.0 to 3600.0 s change delay, 0.1 s steps, default 0.
// - Only inputs 1 to 3 are delayed; the others act at once.
// - Two five-digit polarity settings, one digit per input, default all 0.
// - Mode 0 asserts on connection to common; mode 1 inverts that sense.
// - Mode selects switch or pulse on main output; pulse limited to 100 kHz.
// - Five output terminals each have a function selector of 0 to 41.
// - Selector reset codes: board relay 2, first collector 1, extension 4, others 0.
// - Code 0 leaves the terminal inactive.
// - Code 1 is active while the drive runs with output.
// - Code 2 is active when the drive stopped on a fault.
// - Code 5 is active at zero frequency while running, inactive at stop.
// - Code 6 is active when motor load passes the overload pre-warning level.
// - Code 7 is active 10 s before drive overload protection acts.
// - Codes 8 and 9 are active once the count reaches target or mid target.
// - Code 10 is active when actual length exceeds the length setpoint.
// - Code 11 gives one 250 ms pulse per sequence program cycle.
// - Code 12 is active once accumulated running time exceeds its threshold.
`timescale 1ns/1ns
`include "dtio_regs.vh"
module dtio_top #(
  parameter AW             = 16,
  parameter DW             = 16,
  parameter CW             = 32,
  parameter TICK_CYCLES    = `DTIO_TICK_CYCLES,
  parameter PLC_CYCLES     = `DTIO_PLC_PULSE_CYCLES,
  parameter PULSE_MIN_CYC  = `DTIO_PULSE_MIN_CYCLES
) (
  // Clock and reset
  input  wire            REF_CLK,
  input  wire            RSTN,
  // Digital input pins, high = connected to common_return
  input  wire [9:0]      DIGITAL_INPUT_PIN,
  // Polarity digits, bit n = digit of input n+1 (A: 1-5, B: 6-10)
  input  wire [4:0]      INPUT_POLARITY_SELECT_A,
  input  wire [4:0]      INPUT_POLARITY_SELECT_B,
  // Change delays in 0.1 s units
  input  wire [DW-1:0]   INPUT1_CHANGE_DELAY,
  input  wire [DW-1:0]   INPUT2_CHANGE_DELAY,
  input  wire [DW-1:0]   INPUT3_CHANGE_DELAY,
  // Conditioned inputs
  output reg  [9:0]      DIGITAL_INPUT_ACTIVE,
  output reg  [2:0]      INPUT_DELAY_PENDING,
  // Analog channels: 0 voltage, 1 second, 2 extension
  input  wire [2:0]      BELOW_MIN_HANDLING_SELECT,
  input  wire [2:0]      AIN_BELOW_MIN,
  input  wire [3*AW-1:0] AIN_SCALED,
  input  wire [3*AW-1:0] AIN_MIN_SETTING,
  output reg  [3*AW-1:0] AIN_SETTING,
  // Output selector load port
  input  wire            MAIN_OUTPUT_MODE_SELECT,
  input  wire [4:0]      FUNCTION_SELECT_WRITE,
  input  wire [5:0]      FUNCTION_SELECT_DATA,
  output reg  [29:0]     FUNCTION_SELECT_READBACK,
  // Pulse output period in clock cycles
  input  wire [19:0]     PULSE_PERIOD_CYCLES,
  // Drive status
  input  wire            DRIVE_RUNNING,
  input  wire            DRIVE_FAULT_STOP,
  input  wire            FREQUENCY_LEVEL_DETECT_ONE,
  input  wire            FREQUENCY_REACHED,
  input  wire            ZERO_FREQUENCY,
  input  wire            DRIVE_STOPPED,
  input  wire            MOTOR_OVERLOAD_PREWARN,
  input  wire            DRIVE_OVERLOAD_ACCUMULATING,
  input  wire [DW-1:0]   DRIVE_OVERLOAD_REMAINING,
  input  wire [CW-1:0]   COUNT_VALUE,
  input  wire [CW-1:0]   COUNT_TARGET,
  input  wire [CW-1:0]   COUNT_MID_TARGET,
  input  wire [CW-1:0]   ACTUAL_LENGTH,
  input  wire [CW-1:0]   LENGTH_SETPOINT,
  input  wire            SEQUENCE_CYCLE_DONE,
  input  wire [CW-1:0]   RUN_TIME_ACCUM,
  input  wire [CW-1:0]   RUN_TIME_THRESHOLD,
  // Output terminals, high = ON
  output reg             PULSE_OR_SWITCH_TERMINAL,
  output reg             BOARD_RELAY,
  output reg             EXTENSION_RELAY,
  output reg             FIRST_OPEN_COLLECTOR_OUT,
  output reg             EXTENSION_OPEN_COLLECTOR_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Function decode, shared by all five terminals

  function fn_active;
    input [5:0]  code;
    input [12:0] st;
    begin
      if (code == 6'h00)
        fn_active = 1'b0;
      else if (code <= `DTIO_FN_LAST)
        fn_active = st[code[3:0]];
      else
        fn_active = 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and timebase

  reg  [9:0]  pin_meta_r;
  reg  [9:0]  pin_sync_r;
  reg  [31:0] tick_cnt_r;
  reg         tick_r;

  always @(posedge REF_CLK) begin
    if (!RSTN) begin
      pin_meta_r <= 10'h000;
      pin_sync_r <= 10'h000;
    end else begin
      pin_meta_r <= DIGITAL_INPUT_PIN;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Free-running 0.1 s tick; a delay may thus end up to one tick early
  always @(posedge REF_CLK) begin
    if (!RSTN) begin
      tick_cnt_r <= 32'h00000000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
      tick_cnt_r <= 32'h00000000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      tick_r     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input change delay and polarity

  wire [3*DW-1:0] delay_set;
  wire [2:0]      delayed_lvl;
  wire [2:0]      delay_pend;
  wire [9:0]      term_lvl;
  wire [9:0]      polarity;

  assign delay_set = {INPUT3_CHANGE_DELAY, INPUT2_CHANGE_DELAY, INPUT1_CHANGE_DELAY};
  assign polarity  = {INPUT_POLARITY_SELECT_B, INPUT_POLARITY_SELECT_A};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_delay
      dtio_change_delay #(
        .DW          (DW)
      ) u_delay (
        .clk         (REF_CLK),
        .rst_n       (RSTN),
        .tick        (tick_r),
        .delay_ticks (delay_set[gi*DW +: DW]),
        .level_in    (pin_sync_r[gi]),
        .level_out   (delayed_lvl[gi]),
        .pending     (delay_pend[gi])
      );
    end
  endgenerate

  // Delay acts on the raw terminal state, polarity after it
  assign term_lvl = {pin_sync_r[9:3], delayed_lvl};

  always @(posedge REF_CLK) begin
    if (!RSTN) begin
      DIGITAL_INPUT_ACTIVE <= 10'h000;
      INPUT_DELAY_PENDING  <= 3'h0;
    end else begin
      DIGITAL_INPUT_ACTIVE <= term_lvl ^ polarity;
      INPUT_DELAY_PENDING  <= delay_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog below-minimum handling

  reg [3*AW-1:0] ain_nxt;
  integer ci;

  always @* begin
    ain_nxt = AIN_SCALED;
    for (ci = 0; ci < 3; ci = ci + 1) begin
      if (AIN_BELOW_MIN[ci]) begin
        if (BELOW_MIN_HANDLING_SELECT[ci])
          ain_nxt[ci*AW +: AW] = {AW{1'b0}};
        else
          ain_nxt[ci*AW +: AW] = AIN_MIN_SETTING[ci*AW +: AW];
      end
    end
  end

  always @(posedge REF_CLK) begin
    if (!RSTN)
      AIN_SETTING <= {3*AW{1'b0}};
    else
      AIN_SETTING <= ain_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output function selectors

  reg  [5:0]  sel_r [0:4];
  wire [29:0] sel_rst;

  assign sel_rst = {`DTIO_SEL_XOC_RST, `DTIO_SEL_FIRST_OC_RST, `DTIO_SEL_XRELAY_RST,
                    `DTIO_SEL_BRELAY_RST, `DTIO_SEL_MAIN_RST};

  genvar si;
  generate
    for (si = 0; si < 5; si = si + 1) begin : g_sel
      always @(posedge REF_CLK) begin
        if (!RSTN)
          sel_r[si] <= sel_rst[si*6 +: 6];
        else if (FUNCTION_SELECT_WRITE[si] && FUNCTION_SELECT_DATA <= `DTIO_FN_MAX)
          sel_r[si] <= FUNCTION_SELECT_DATA;
      end
    end
  endgenerate

  always @(posedge REF_CLK) begin
    if (!RSTN)
      FUNCTION_SELECT_READBACK <= sel_rst;
    else
      FUNCTION_SELECT_READBACK <= {sel_r[4], sel_r[3], sel_r[2], sel_r[1], sel_r[0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle-complete pulse

  reg [31:0] plc_cnt_r;

  // A new cycle end during the pulse restarts the 250 ms width
  always @(posedge REF_CLK) begin
    if (!RSTN)
      plc_cnt_r <= 32'h00000000;
    else if (SEQUENCE_CYCLE_DONE)
      plc_cnt_r <= PLC_CYCLES;
    else if (plc_cnt_r != 32'h00000000)
      plc_cnt_r <= plc_cnt_r - 32'h00000001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status vector, indexed by function code

  wire [12:0] st;

  assign st[0]  = 1'b0;
  assign st[1]  = DRIVE_RUNNING;
  assign st[2]  = DRIVE_FAULT_STOP;
  assign st[3]  = FREQUENCY_LEVEL_DETECT_ONE;
  assign st[4]  = FREQUENCY_REACHED;
  assign st[5]  = ZERO_FREQUENCY & ~DRIVE_STOPPED;
  assign st[6]  = MOTOR_OVERLOAD_PREWARN;
  assign st[7]  = DRIVE_OVERLOAD_ACCUMULATING &&
                  (DRIVE_OVERLOAD_REMAINING <= `DTIO_OVL_LEAD_TENTHS);
  assign st[8]  = COUNT_VALUE >= COUNT_TARGET;
  assign st[9]  = COUNT_VALUE >= COUNT_MID_TARGET;
  assign st[10] = ACTUAL_LENGTH > LENGTH_SETPOINT;
  assign st[11] = plc_cnt_r != 32'h00000000;
  assign st[12] = RUN_TIME_ACCUM > RUN_TIME_THRESHOLD;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse generator for the main output

  reg  [19:0] pls_cnt_r;
  reg         pls_out_r;
  wire [19:0] per_eff;
  wire [19:0] half_per;

  // Shorter periods are raised so the output never passes 100 kHz
  assign per_eff  = (PULSE_PERIOD_CYCLES < PULSE_MIN_CYC) ?
                    PULSE_MIN_CYC[19:0] : PULSE_PERIOD_CYCLES;
  assign half_per = {1'b0, per_eff[19:1]};

  always @(posedge REF_CLK) begin
    if (!RSTN) begin
      pls_cnt_r <= 20'h00000;
      pls_out_r <= 1'b0;
    end else if (MAIN_OUTPUT_MODE_SELECT != `DTIO_MODE_PULSE) begin
      pls_cnt_r <= 20'h00000;
      pls_out_r <= 1'b0;
    end else if (pls_cnt_r + 20'h00001 >= half_per) begin
      pls_cnt_r <= 20'h00000;
      pls_out_r <= ~pls_out_r;
    end else begin
      pls_cnt_r <= pls_cnt_r + 20'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output terminals

  reg main_sw_nxt;

  always @* begin
    main_sw_nxt = fn_active(sel_r[`DTIO_IDX_MAIN], st);
    if (MAIN_OUTPUT_MODE_SELECT == `DTIO_MODE_PULSE)
      main_sw_nxt = pls_out_r;
  end

  always @(posedge REF_CLK) begin
    if (!RSTN) begin
      PULSE_OR_SWITCH_TERMINAL     <= 1'b0;
      BOARD_RELAY                  <= 1'b0;
      EXTENSION_RELAY              <= 1'b0;
      FIRST_OPEN_COLLECTOR_OUT     <= 1'b0;
      EXTENSION_OPEN_COLLECTOR_OUT <= 1'b0;
    end else begin
      PULSE_OR_SWITCH_TERMINAL     <= main_sw_nxt;
      BOARD_RELAY                  <= fn_active(sel_r[`DTIO_IDX_BRELAY], st);
      EXTENSION_RELAY              <= fn_active(sel_r[`DTIO_IDX_XRELAY], st);
      FIRST_OPEN_COLLECTOR_OUT     <= fn_active(sel_r[`DTIO_IDX_FIRST_OC], st);
      EXTENSION_OPEN_COLLECTOR_OUT <= fn_active(sel_r[`DTIO_IDX_XOC], st);
    end
  end

endmodule

// ---- verif/dtio_field.sv ----
// Purpose: Field wiring model: contacts that close terminals to common.
// Assumes: A closed contact reads high at the terminal.
// Notes:   Contacts move off the sampling edge, like a slow switch.
`timescale 1ns/1ns
module dtio_field (
  // Clock
  input  wire       clk,
  // Contact commands
  input  wire [9:0] closed,
  // Terminal levels
  output reg  [9:0] pin
);
  initial pin = 10'h000;
  always @(negedge clk) begin
    pin <= closed;
  end
endmodule

// ---- verif/dtio_top_chk.sv ----
// Purpose: Port-level checker for the terminal conditioning block.
// Assumes: Status and analog inputs share the block clock.
// Notes:   Helper counters measure pulse widths and runs.
`timescale 1ns/1ns
module dtio_top_chk #(
  parameter AW            = 16,
  parameter PLC_CYCLES    = 20,
  parameter PULSE_MIN_CYC = 1000
) (
  // Clock and reset
  input wire            REF_CLK,
  input wire            RSTN,
  // Inputs
  input wire [9:0]      DIGITAL_INPUT_PIN,
  input wire [4:0]      INPUT_POLARITY_SELECT_A,
  input wire [9:0]      DIGITAL_INPUT_ACTIVE,
  // Analog
  input wire [2:0]      BELOW_MIN_HANDLING_SELECT,
  input wire [2:0]      AIN_BELOW_MIN,
  input wire [3*AW-1:0] AIN_MIN_SETTING,
  input wire [3*AW-1:0] AIN_SETTING,
  // Outputs and status
  input wire            MAIN_OUTPUT_MODE_SELECT,
  input wire [29:0]     FUNCTION_SELECT_READBACK,
  input wire            DRIVE_RUNNING,
  input wire            DRIVE_FAULT_STOP,
  input wire            SEQUENCE_CYCLE_DONE,
  input wire            PULSE_OR_SWITCH_TERMINAL,
  input wire            BOARD_RELAY,
  input wire            EXTENSION_RELAY,
  input wire            FIRST_OPEN_COLLECTOR_OUT,
  input wire            EXTENSION_OPEN_COLLECTOR_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////
  reg [7:0]  hi_cnt_r;
  reg [11:0] run_r;
  reg        pulse_q_r;
  // Run length saturates so a long steady level never wraps to a short one
  always @(posedge REF_CLK) begin
    if (!RSTN) begin
      hi_cnt_r  <= 8'h00;
      run_r     <= 12'h000;
      pulse_q_r <= 1'b0;
    end else begin
      hi_cnt_r  <= EXTENSION_OPEN_COLLECTOR_OUT ? hi_cnt_r + 8'h01 : 8'h00;
      pulse_q_r <= PULSE_OR_SWITCH_TERMINAL;
      if (PULSE_OR_SWITCH_TERMINAL != pulse_q_r)
        run_r <= 12'h001;
      else if (run_r != 12'hfff)
        run_r <= run_r + 12'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_plc_go;
    FUNCTION_SELECT_READBACK[29:24] == 6'h0b && SEQUENCE_CYCLE_DONE;
  endsequence
  sequence s_plc_end;
    $fell(EXTENSION_OPEN_COLLECTOR_OUT) && FUNCTION_SELECT_READBACK[29:24] == 6'h0b;
  endsequence
  chk_ain_min_point: assert property (
    AIN_BELOW_MIN[0] && !BELOW_MIN_HANDLING_SELECT[0]
    |=> AIN_SETTING[AW-1:0] == $past(AIN_MIN_SETTING[AW-1:0]))
    else $error("minimum-point setting not used");
  chk_ain_zero_pct: assert property (
    AIN_BELOW_MIN[1] && BELOW_MIN_HANDLING_SELECT[1] |=> AIN_SETTING[2*AW-1:AW] == '0)
    else $error("below-minimum channel not zero");
  chk_ain_third_chan: assert property (
    AIN_BELOW_MIN[2] && BELOW_MIN_HANDLING_SELECT[2] |=> AIN_SETTING[3*AW-1:2*AW] == '0)
    else $error("third channel digit ignored");
  // The pin path is two stages slower than polarity, so the pin must hold still
  chk_input_sense_on: assert property (
    ((DIGITAL_INPUT_PIN[3] ^ INPUT_POLARITY_SELECT_A[3]) && $stable(DIGITAL_INPUT_PIN[3]))[*5]
    |-> DIGITAL_INPUT_ACTIVE[3])
    else $error("undelayed input not asserted");
  chk_input_sense_off: assert property (
    ((DIGITAL_INPUT_PIN[3] == INPUT_POLARITY_SELECT_A[3]) && $stable(DIGITAL_INPUT_PIN[3]))[*5]
    |-> !DIGITAL_INPUT_ACTIVE[3])
    else $error("undelayed input not released");
  chk_code_none_idle: assert property (
    FUNCTION_SELECT_READBACK[17:12] == 6'h00 |-> !EXTENSION_RELAY)
    else $error("terminal with no function is on");
  chk_run_follow: assert property (
    $past(RSTN) && FUNCTION_SELECT_READBACK[23:18] == 6'h01
    |-> FIRST_OPEN_COLLECTOR_OUT == $past(DRIVE_RUNNING))
    else $error("running output does not follow status");
  chk_fault_follow: assert property (
    $past(RSTN) && FUNCTION_SELECT_READBACK[11:6] == 6'h02
    |-> BOARD_RELAY == $past(DRIVE_FAULT_STOP))
    else $error("fault output does not follow status");
  chk_plc_start: assert property (
    s_plc_go |-> ##2 EXTENSION_OPEN_COLLECTOR_OUT[*8])
    else $error("cycle pulse did not start");
  chk_plc_width: assert property (
    s_plc_end |-> hi_cnt_r == PLC_CYCLES)
    else $error("cycle pulse width wrong");
  chk_pulse_rate_cap: assert property (
    MAIN_OUTPUT_MODE_SELECT && $past(MAIN_OUTPUT_MODE_SELECT, 2)
    && $changed(PULSE_OR_SWITCH_TERMINAL) |-> run_r >= PULSE_MIN_CYC / 2 - 1)
    else $error("pulse output faster than its ceiling");
endmodule
bind dtio_top dtio_top_chk #(.AW(AW), .PLC_CYCLES(PLC_CYCLES), .PULSE_MIN_CYC(PULSE_MIN_CYC))
  u_dtio_top_chk (.REF_CLK, .RSTN, .DIGITAL_INPUT_PIN, .INPUT_POLARITY_SELECT_A,
  .DIGITAL_INPUT_ACTIVE, .BELOW_MIN_HANDLING_SELECT, .AIN_BELOW_MIN, .AIN_MIN_SETTING,
  .AIN_SETTING, .MAIN_OUTPUT_MODE_SELECT, .FUNCTION_SELECT_READBACK, .DRIVE_RUNNING,
  .DRIVE_FAULT_STOP, .SEQUENCE_CYCLE_DONE, .PULSE_OR_SWITCH_TERMINAL, .BOARD_RELAY,
  .EXTENSION_RELAY, .FIRST_OPEN_COLLECTOR_OUT, .EXTENSION_OPEN_COLLECTOR_OUT);

// ---- verif/dtio_top_tb.sv ----
// Purpose: Self-checking bench for the terminal conditioning block.
// Assumes: Short tick and pulse parameters keep the run brief.
// Notes:   All inputs change on the falling edge.
`timescale 1ns/1ns
module dtio_top_tb;
  localparam int LIMIT = 6000;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [9:0]  closed = 10'h000;
  logic [9:0]  pin;
  logic [4:0]  pol_a = 5'h00, pol_b = 5'h00, fsw = 5'h00;
  logic [15:0] d1 = 16'h0000, d2 = 16'h0000, d3 = 16'h0000, rem = 16'h0064;
  logic [2:0]  bsel = 3'h0, below = 3'h0;
  logic [47:0] scl = 48'h3333_2222_1111, mn = 48'h6666_5555_4444;
  logic [5:0]  fsd = 6'h00;
  logic [19:0] per = 20'h0000a;
  logic        mode = 1'b0, run = 1'b0, flt = 1'b0, fdt = 1'b0, frq = 1'b0, zf = 1'b0;
  logic        stp = 1'b0, pw = 1'b0, acc = 1'b0, seq = 1'b0;
  logic [31:0] cv = 32'h0, ct = 32'ha, cm = 32'h5, al = 32'h0, ls = 32'h7;
  logic [31:0] rt = 32'h0, rth = 32'h9;
  wire  [9:0]  act;
  wire  [2:0]  pend;
  wire  [47:0] ain;
  wire  [29:0] rb;
  wire         o_main, o_br, o_xr, o_oc, o_xoc;
  int          n_mismatch = 0, n_tests = 0, cyc = 0;
  dtio_top #(.TICK_CYCLES(10), .PLC_CYCLES(20)) u_dtio_top (
    .REF_CLK(clk), .RSTN(rstn), .DIGITAL_INPUT_PIN(pin),
    .INPUT_POLARITY_SELECT_A(pol_a), .INPUT_POLARITY_SELECT_B(pol_b),
    .INPUT1_CHANGE_DELAY(d1), .INPUT2_CHANGE_DELAY(d2), .INPUT3_CHANGE_DELAY(d3),
    .DIGITAL_INPUT_ACTIVE(act), .INPUT_DELAY_PENDING(pend),
    .BELOW_MIN_HANDLING_SELECT(bsel), .AIN_BELOW_MIN(below), .AIN_SCALED(scl),
    .AIN_MIN_SETTING(mn), .AIN_SETTING(ain), .MAIN_OUTPUT_MODE_SELECT(mode),
    .FUNCTION_SELECT_WRITE(fsw), .FUNCTION_SELECT_DATA(fsd),
    .FUNCTION_SELECT_READBACK(rb), .PULSE_PERIOD_CYCLES(per), .DRIVE_RUNNING(run),
    .DRIVE_FAULT_STOP(flt), .FREQUENCY_LEVEL_DETECT_ONE(fdt), .FREQUENCY_REACHED(frq),
    .ZERO_FREQUENCY(zf), .DRIVE_STOPPED(stp), .MOTOR_OVERLOAD_PREWARN(pw),
    .DRIVE_OVERLOAD_ACCUMULATING(acc), .DRIVE_OVERLOAD_REMAINING(rem),
    .COUNT_VALUE(cv), .COUNT_TARGET(ct), .COUNT_MID_TARGET(cm), .ACTUAL_LENGTH(al),
    .LENGTH_SETPOINT(ls), .SEQUENCE_CYCLE_DONE(seq), .RUN_TIME_ACCUM(rt),
    .RUN_TIME_THRESHOLD(rth), .PULSE_OR_SWITCH_TERMINAL(o_main), .BOARD_RELAY(o_br),
    .EXTENSION_RELAY(o_xr), .FIRST_OPEN_COLLECTOR_OUT(o_oc),
    .EXTENSION_OPEN_COLLECTOR_OUT(o_xoc));
  dtio_field u_dtio_field (.clk(clk), .closed(closed), .pin(pin));
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic load(input logic [4:0] wr, input logic [5:0] code);
    @(negedge clk);
    fsw = wr;
    fsd = code;
    @(negedge clk);
    fsw = 5'h00;
    cycles(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_analog;
    logic [47:0] e;
    for (int s = 0; s < 16; s++) begin
      @(negedge clk);
      bsel = s[2:0];
      below = s[3] ? 3'h2 : 3'h7;
      cycles(2);
      for (int c = 0; c < 3; c++)
        e[c*16 +: 16] = !below[c] ? scl[c*16 +: 16] : bsel[c] ? 16'h0000 : mn[c*16 +: 16];
      check(ain, e);
    end
  endtask
  task automatic t_polarity;
    logic [9:0] p [4] = '{10'h000, 10'h3ff, 10'h155, 10'h0f0};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      {pol_b, pol_a} = p[i];
      closed = 10'h2a5 ^ {i[1:0], 8'h00};
      cycles(8);
      check(act, closed ^ p[i]);
    end
  endtask
  task automatic t_delay;
    int t = 6;
    @(negedge clk);
    {pol_b, pol_a} = 10'h000;
    closed = 10'h000;
    cycles(8);
    d1 = 16'h0003;
    d2 = 16'h0003;
    closed = 10'h009;
    cycles(6);
    check(act[3], 1'b1);
    check({act[0], pend[0]}, 2'b01);
    while (act[0] !== 1'b1 && t < 60) begin
      cycles(1);
      t++;
    end
    check(t >= 20 && t <= 35, 1'b1);
    closed = 10'h00b;
    cycles(10);
    closed = 10'h009;
    cycles(40);
    check(act[1], 1'b0);
    closed = 10'h008;
    cycles(15);
    check(act[0], 1'b1);
    cycles(25);
    check(act[0], 1'b0);
  endtask
  task automatic set_cond(input int c, input logic v);
    case (c)
      0: {run, flt} = {v, v};
      1: run = v;
      2: flt = v;
      3: fdt = v;
      4: frq = v;
      5: {run, zf} = {v, v};
      6: pw = v;
      7: acc = v;
      8: cv = v ? ct : ct - 32'h1;
      9: cv = v ? cm : cm - 32'h1;
      10: al = v ? ls + 32'h1 : ls;
      default: rt = v ? rth + 32'h1 : rth;
    endcase
  endtask
  task automatic t_mux;
    for (int c = 0; c < 13; c++) begin
      if (c == 11)
        continue;
      load(5'h06, c[5:0]);
      for (int v = 1; v >= 0; v--) begin
        @(negedge clk);
        set_cond(c, v[0]);
        cycles(2);
        check({o_br, o_xr}, {2{c != 0 && v == 1}});
      end
    end
    load(5'h02, 6'h07);
    {acc, rem} = {1'b1, 16'h0065};
    cycles(2);
    check(o_br, 1'b0);
    load(5'h02, 6'h05);
    {zf, stp} = 2'b11;
    cycles(2);
    check(o_br, 1'b0);
    load(5'h02, 6'h2a);
    check(rb[11:6], 6'h05);
    load(5'h02, 6'h29);
    check({rb[11:6], o_br}, {6'h29, 1'b0});
    {zf, stp, acc, rem} = {3'b000, 16'h0064};
  endtask
  task automatic t_plc;
    int n = 0;
    load(5'h10, 6'h0b);
    seq = 1'b1;
    @(negedge clk);
    seq = 1'b0;
    repeat (40) begin
      @(negedge clk);
      n += o_xoc;
    end
    check(n, 20);
  endtask
  task automatic t_pulse;
    int t = 0;
    load(5'h01, 6'h01);
    run = 1'b1;
    mode = 1'b1;
    while (o_main !== 1'b1 && t < 1200) begin
      @(negedge clk);
      t++;
    end
    t = 0;
    while (o_main === 1'b1 && t < 1200) begin
      @(negedge clk);
      t++;
    end
    check(t, 500);
    mode = 1'b0;
    cycles(3);
    check(o_main, 1'b1);
    run = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cycles(10);
    rstn = 1'b1;
    cycles(2);
    check(rb, {6'h04, 6'h01, 6'h00, 6'h02, 6'h00});
    t_analog;
    t_polarity;
    t_delay;
    t_mux;
    t_plc;
    t_pulse;
    final_report;
  end
endmodule
